// ---- pcsd_map.svh ----
`ifndef PCSD_MAP_SVH
`define PCSD_MAP_SVH

// Register byte addresses on the plain register port.
`define PCSD_OFF_CS0_START 32'h0b00_0320
`define PCSD_OFF_CS0_STOP 32'h0b00_0322
`define PCSD_OFF_CS0_UPPER 32'h0b00_0324
`define PCSD_OFF_CS1_START 32'h0b00_0326
`define PCSD_OFF_CS1_STOP 32'h0b00_0328
`define PCSD_OFF_CS1_UPPER 32'h0b00_032a
`define PCSD_OFF_MODE 32'h0b00_032c

// Field positions in the chip select mode control register.
`define PCSD_CS1_MIO_BIT 7
`define PCSD_CS1_DSZ_BIT 6
`define PCSD_CS1_MD_MSB 5
`define PCSD_CS1_MD_LSB 4
`define PCSD_CS0_MIO_BIT 3
`define PCSD_CS0_DSZ_BIT 2
`define PCSD_CS0_MD_MSB 1
`define PCSD_CS0_MD_LSB 0

// Implemented widths and reset values.
`define PCSD_START1_W 15
`define PCSD_UPPER_W 12
`define PCSD_MODE_W 8
`define PCSD_RST_WORD 16'h0000
`define PCSD_RST_UPPER 12'h000
`define PCSD_RST_START1 15'h0000
`define PCSD_RST_MODE 8'h00

`endif

// ---- pcsd_pkg.sv ----
package pcsd_pkg;

  typedef logic [31:0] pcsd_addr_t;
  typedef logic [15:0] pcsd_word_t;
  typedef logic [27:0] pcsd_sys_addr_t;

  // Qualifier encoding follows the two-bit mode field order 00, 01, 10, 11.
  typedef enum logic [1:0] {
    PCSD_QM_OFF,
    PCSD_QM_READ,
    PCSD_QM_WRITE,
    PCSD_QM_DECODE
  } pcsd_qmode_t;

endpackage

// ---- pcsd_sel_if.sv ----
`timescale 1ns/1ps
interface pcsd_sel_if;
  import pcsd_pkg::*;

  logic [15:0] start;
  logic [15:0] stop;
  logic [11:0] upper;
  pcsd_qmode_t qmode;
  logic memory_not_io;
  logic width_select;

  modport cfg (
    output start,
    output stop,
    output upper,
    output qmode,
    output memory_not_io,
    output width_select
  );

  modport dec (
    input start,
    input stop,
    input upper,
    input qmode,
    input memory_not_io,
    input width_select
  );
endinterface

// ---- pcsd_decode.sv ----
`timescale 1ns/1ps
module pcsd_decode (
  pcsd_sel_if.dec cfg,
  input wire pcsd_pkg::pcsd_sys_addr_t sys_addr_i,
  input wire logic mem_cycle_i,
  input wire logic rd_strobe_i,
  input wire logic wr_strobe_i,
  input wire logic mem_width16_n_i,
  input wire logic io_width16_n_i,
  output logic hit_o,
  output logic wide_o
);
  import pcsd_pkg::*;

  // Both limits are inclusive; a 16-bit select drops bit 0 on every side.
  function automatic logic in_window(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi, input logic wide);
    logic [15:0] m;
    m = wide ? 16'hfffe : 16'hffff;
    return ((a & m) >= (lo & m)) && ((a & m) <= (hi & m));
  endfunction

  wire window_ok = in_window(sys_addr_i[15:0], cfg.start, cfg.stop,
                             cfg.width_select);
  wire upper_ok = (sys_addr_i[27:16] == cfg.upper);
  wire type_ok = (mem_cycle_i == cfg.memory_not_io);
  wire qual_ok = (cfg.qmode == PCSD_QM_DECODE) ||
                 (cfg.qmode == PCSD_QM_READ && rd_strobe_i) ||
                 (cfg.qmode == PCSD_QM_WRITE && wr_strobe_i);
  wire ext_wide = mem_cycle_i ? !mem_width16_n_i : !io_width16_n_i;

  assign hit_o = window_ok && upper_ok && type_ok && qual_ok;
  assign wide_o = cfg.width_select || ext_wide;
endmodule // pcsd_decode

// ---- pcsd_top.sv ----
`timescale 1ns/1ps
`include "pcsd_map.svh"

// Summary of operation
// - Address low half within inclusive start/stop window.
// - Address bits 27:16 equal upper match value.
// - Mode qualifier must be met by bus cycle.
// - Sixteen-bit select ignores address bit zero.
// - Select one mode: off, read, write, decode.
// - Select zero mode uses same encoding.
// - Bit 7: select one I/O or memory.
// - Bit 3: select zero I/O or memory.
// - Bit 6: select one width, peripheral may widen.
// - Bit 2: select zero width, same way.
// - Reserved register bits read as zero.
// - Clock-domain reset clears; other resets hold configuration, clear selects.
// - Select one start bit 15 reads zero.
module pcsd_top #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic other_reset_i,
  input wire pcsd_pkg::pcsd_addr_t reg_addr_i,
  input wire pcsd_pkg::pcsd_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output pcsd_pkg::pcsd_word_t reg_rdata_o,
  input wire pcsd_pkg::pcsd_sys_addr_t sys_addr_i,
  input wire logic mem_cycle_i,
  input wire logic rd_strobe_i,
  input wire logic wr_strobe_i,
  input wire logic mem_width16_n_i,
  input wire logic io_width16_n_i,
  output logic chip_select_zero_o,
  output logic chip_select_one_o,
  output logic cs0_cycle16_o,
  output logic cs1_cycle16_o
);
  import pcsd_pkg::*;

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2.");
  end

  // Configuration registers.
  logic [15:0] cs0_start_q;
  logic [15:0] cs0_stop_q;
  logic [11:0] cs0_upper_q;
  logic [14:0] cs1_start_q;
  logic [15:0] cs1_stop_q;
  logic [11:0] cs1_upper_q;
  logic [7:0] mode_q;
  pcsd_word_t rdata_q;

  // Outputs and width indication synchronisers.
  logic cs0_q;
  logic cs1_q;
  logic cs0_wide_q;
  logic cs1_wide_q;
  logic [SYNC_STAGES-1:0] mem_w16_sync_q;
  logic [SYNC_STAGES-1:0] io_w16_sync_q;

  // Address decode of the register port.
  wire sel_cs0_start = (reg_addr_i == `PCSD_OFF_CS0_START);
  wire sel_cs0_stop = (reg_addr_i == `PCSD_OFF_CS0_STOP);
  wire sel_cs0_upper = (reg_addr_i == `PCSD_OFF_CS0_UPPER);
  wire sel_cs1_start = (reg_addr_i == `PCSD_OFF_CS1_START);
  wire sel_cs1_stop = (reg_addr_i == `PCSD_OFF_CS1_STOP);
  wire sel_cs1_upper = (reg_addr_i == `PCSD_OFF_CS1_UPPER);
  wire sel_mode = (reg_addr_i == `PCSD_OFF_MODE);

  // Unmapped reads return zero, as do the reserved high bits.
  wire pcsd_word_t rd_mux =
    sel_cs0_start ? cs0_start_q :
    sel_cs0_stop ? cs0_stop_q :
    sel_cs0_upper ? {4'h0, cs0_upper_q} :
    sel_cs1_start ? {1'b0, cs1_start_q} :
    sel_cs1_stop ? cs1_stop_q :
    sel_cs1_upper ? {4'h0, cs1_upper_q} :
    sel_mode ? {8'h00, mode_q} :
    `PCSD_RST_WORD;

  // Only reset_i stands for the clock-domain reset of this register file.
  // Every other reset leaves the configuration alone.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cs0_start_q <= `PCSD_RST_WORD;
      cs0_stop_q <= `PCSD_RST_WORD;
      cs0_upper_q <= `PCSD_RST_UPPER;
    end else if (reg_wr_i) begin
      if (sel_cs0_start) cs0_start_q <= reg_wdata_i;
      if (sel_cs0_stop) cs0_stop_q <= reg_wdata_i;
      if (sel_cs0_upper) cs0_upper_q <= reg_wdata_i[11:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cs1_start_q <= `PCSD_RST_START1;
      cs1_stop_q <= `PCSD_RST_WORD;
      cs1_upper_q <= `PCSD_RST_UPPER;
    end else if (reg_wr_i) begin
      if (sel_cs1_start) cs1_start_q <= reg_wdata_i[14:0];
      if (sel_cs1_stop) cs1_stop_q <= reg_wdata_i;
      if (sel_cs1_upper) cs1_upper_q <= reg_wdata_i[11:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mode_q <= `PCSD_RST_MODE;
    end else if (reg_wr_i && sel_mode) begin
      mode_q <= reg_wdata_i[7:0];
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_q <= `PCSD_RST_WORD;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : `PCSD_RST_WORD;
    end
  end

  // The width indications are pins, so they cross into this clock first.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || other_reset_i) begin
      mem_w16_sync_q <= '1;
      io_w16_sync_q <= '1;
    end else begin
      mem_w16_sync_q <= {mem_w16_sync_q[SYNC_STAGES-2:0], mem_width16_n_i};
      io_w16_sync_q <= {io_w16_sync_q[SYNC_STAGES-2:0], io_width16_n_i};
    end
  end

  wire mem_w16_n_s = mem_w16_sync_q[SYNC_STAGES-1];
  wire io_w16_n_s = io_w16_sync_q[SYNC_STAGES-1];

  pcsd_sel_if sel0_if ();
  pcsd_sel_if sel1_if ();

  assign sel0_if.start = cs0_start_q;
  assign sel0_if.stop = cs0_stop_q;
  assign sel0_if.upper = cs0_upper_q;
  assign sel0_if.qmode = pcsd_qmode_t'(mode_q[`PCSD_CS0_MD_MSB:`PCSD_CS0_MD_LSB]);
  assign sel0_if.memory_not_io = mode_q[`PCSD_CS0_MIO_BIT];
  assign sel0_if.width_select = mode_q[`PCSD_CS0_DSZ_BIT];

  assign sel1_if.start = {1'b0, cs1_start_q};
  assign sel1_if.stop = cs1_stop_q;
  assign sel1_if.upper = cs1_upper_q;
  assign sel1_if.qmode = pcsd_qmode_t'(mode_q[`PCSD_CS1_MD_MSB:`PCSD_CS1_MD_LSB]);
  assign sel1_if.memory_not_io = mode_q[`PCSD_CS1_MIO_BIT];
  assign sel1_if.width_select = mode_q[`PCSD_CS1_DSZ_BIT];

  logic cs0_hit;
  logic cs1_hit;
  logic cs0_wide;
  logic cs1_wide;

  pcsd_decode u_dec0 (
    .cfg(sel0_if.dec),
    .sys_addr_i(sys_addr_i),
    .mem_cycle_i(mem_cycle_i),
    .rd_strobe_i(rd_strobe_i),
    .wr_strobe_i(wr_strobe_i),
    .mem_width16_n_i(mem_w16_n_s),
    .io_width16_n_i(io_w16_n_s),
    .hit_o(cs0_hit),
    .wide_o(cs0_wide)
  );

  pcsd_decode u_dec1 (
    .cfg(sel1_if.dec),
    .sys_addr_i(sys_addr_i),
    .mem_cycle_i(mem_cycle_i),
    .rd_strobe_i(rd_strobe_i),
    .wr_strobe_i(wr_strobe_i),
    .mem_width16_n_i(mem_w16_n_s),
    .io_width16_n_i(io_w16_n_s),
    .hit_o(cs1_hit),
    .wide_o(cs1_wide)
  );

  // Registering the selects costs one cycle of latency but gives glitch-free pins.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || other_reset_i) begin
      cs0_q <= 1'b0;
      cs1_q <= 1'b0;
      cs0_wide_q <= 1'b0;
      cs1_wide_q <= 1'b0;
    end else begin
      cs0_q <= cs0_hit;
      cs1_q <= cs1_hit;
      cs0_wide_q <= cs0_hit && cs0_wide;
      cs1_wide_q <= cs1_hit && cs1_wide;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign chip_select_zero_o = cs0_q;
  assign chip_select_one_o = cs1_q;
  assign cs0_cycle16_o = cs0_wide_q;
  assign cs1_cycle16_o = cs1_wide_q;

  wire any_reset = reset_i || other_reset_i;

  cs0_off_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[1:0] == 2'b00 |=> !chip_select_zero_o)
    else $error("Disabled select zero asserted.");

  cs1_off_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[5:4] == 2'b00 |=> !chip_select_one_o)
    else $error("Disabled select one asserted.");

  read_qual_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[5:4] == 2'b01 && !rd_strobe_i |=> !chip_select_one_o)
    else $error("Read qualified select without read strobe.");

  write_qual_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[1:0] == 2'b10 && !wr_strobe_i |=> !chip_select_zero_o)
    else $error("Write qualified select without write strobe.");

  cs1_type_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mem_cycle_i != mode_q[7] |=> !chip_select_one_o)
    else $error("Select one in wrong cycle type.");

  cs0_type_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mem_cycle_i != mode_q[3] |=> !chip_select_zero_o)
    else $error("Select zero in wrong cycle type.");

  window_low_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !mode_q[6] && sys_addr_i[15:0] < {1'b0, cs1_start_q} |=> !chip_select_one_o)
    else $error("Select one below its start address.");

  window_high_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !mode_q[6] && sys_addr_i[15:0] > cs1_stop_q |=> !chip_select_one_o)
    else $error("Select one above its stop address.");

  upper_match_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    sys_addr_i[27:16] != cs1_upper_q |=> !chip_select_one_o)
    else $error("Select one with upper address mismatch.");

  bit0_ignore_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[7:4] == 4'hf && mem_cycle_i && sys_addr_i[27:16] == cs1_upper_q &&
    sys_addr_i[15:1] >= cs1_start_q[14:1] && sys_addr_i[15:1] <= cs1_stop_q[15:1]
    |=> chip_select_one_o)
    else $error("Sixteen-bit select one missed a bit-zero match.");

  force_wide_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    chip_select_one_o && $past(mode_q[6]) |-> cs1_cycle16_o)
    else $error("Forced sixteen-bit select one ran narrow.");

  narrow_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !mode_q[2] && mem_cycle_i && mem_w16_n_s |=> !cs0_cycle16_o)
    else $error("Eight-bit select zero widened without request.");

  reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && (sel_mode || sel_cs1_upper) |=> reg_rdata_o[15:12] == 4'h0)
    else $error("Reserved bits read as nonzero.");

  hold_cfg_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    other_reset_i && !reg_wr_i |=> $stable(mode_q) && $stable(cs1_stop_q))
    else $error("Configuration lost on a non-clock reset.");

  start_msb_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && sel_cs1_start |=> !reg_rdata_o[15])
    else $error("Start address bit 15 read as one.");

  cs0_low_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !mode_q[2] && sys_addr_i[15:0] < cs0_start_q |=> !chip_select_zero_o)
    else $error("Select zero below its start address.");

  cs0_high_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !mode_q[2] && sys_addr_i[15:0] > cs0_stop_q |=> !chip_select_zero_o)
    else $error("Select zero above its stop address.");

  cs0_upper_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    sys_addr_i[27:16] != cs0_upper_q |=> !chip_select_zero_o)
    else $error("Select zero with upper address mismatch.");

  cs0_read_qual_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[1:0] == 2'h1 && !rd_strobe_i |=> !chip_select_zero_o)
    else $error("Read qualified select zero without read strobe.");

  cs1_write_qual_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[5:4] == 2'h2 && !wr_strobe_i |=> !chip_select_one_o)
    else $error("Write qualified select one without write strobe.");

  cs1_decode_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    mode_q[7:4] == 4'hb && mem_cycle_i && sys_addr_i[27:16] == cs1_upper_q &&
    sys_addr_i[15:0] >= {1'b0, cs1_start_q} && sys_addr_i[15:0] <= cs1_stop_q
    |=> chip_select_one_o)
    else $error("Decode-only select one missed a match.");

  io_narrow_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !mode_q[6] && !mem_cycle_i && io_w16_n_s |=> !cs1_cycle16_o)
    else $error("Eight-bit select one widened without request.");

  cs0_wide_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    chip_select_zero_o && $past(mode_q[2]) |-> cs0_cycle16_o)
    else $error("Forced sixteen-bit select zero ran narrow.");
endmodule // pcsd_top

// ---- pcsd_periph_model.sv ----
`timescale 1ns/1ps
module pcsd_periph_model (
  input wire logic sys_clk_i,
  input wire logic want_mem16_i,
  input wire logic want_io16_i,
  output logic mem_width16_n_o,
  output logic io_width16_n_o
);
  // The width pins have pull-ups, so an idle pin reads high rather than a stale level.
  initial begin
    mem_width16_n_o = 1'b1;
    io_width16_n_o = 1'b1;
  end
  always @(posedge sys_clk_i) begin
    mem_width16_n_o <= ~want_mem16_i;
    io_width16_n_o <= ~want_io16_i;
  end
endmodule // pcsd_periph_model

// ---- programmable_chip_select_decode_tb_top.sv ----
`timescale 1ns/1ps
`include "pcsd_map.svh"
module programmable_chip_select_decode_tb_top;
  import pcsd_pkg::*;
  logic sys_clk, reset, other_reset, reg_wr, reg_rd, mem_cycle, rd_strobe, wr_strobe;
  logic want_mem16, want_io16, mem_w16_n, io_w16_n, cs0, cs1, c16_0, c16_1;
  pcsd_addr_t reg_addr;
  pcsd_word_t reg_wdata, reg_rdata;
  pcsd_sys_addr_t sys_addr;
  int errors, num_checks, i, n, k, a;
  int cfg[7];
  logic [1:0] e0, e1;
  pcsd_word_t exp_q[$];
  pcsd_addr_t offs[7] = '{`PCSD_OFF_CS0_START, `PCSD_OFF_CS0_STOP, `PCSD_OFF_CS0_UPPER,
    `PCSD_OFF_CS1_START, `PCSD_OFF_CS1_STOP, `PCSD_OFF_CS1_UPPER, `PCSD_OFF_MODE};
  pcsd_word_t msk[7] = '{16'hffff, 16'hffff, 16'h0fff, 16'h7fff, 16'hffff, 16'h0fff, 16'h00ff};

  pcsd_top u_dut (
    .sys_clk_i(sys_clk), .reset_i(reset), .other_reset_i(other_reset),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .sys_addr_i(sys_addr), .mem_cycle_i(mem_cycle),
    .rd_strobe_i(rd_strobe), .wr_strobe_i(wr_strobe), .mem_width16_n_i(mem_w16_n),
    .io_width16_n_i(io_w16_n), .chip_select_zero_o(cs0), .chip_select_one_o(cs1),
    .cs0_cycle16_o(c16_0), .cs1_cycle16_o(c16_1)
  );

  pcsd_periph_model u_periph (
    .sys_clk_i(sys_clk), .want_mem16_i(want_mem16), .want_io16_i(want_io16),
    .mem_width16_n_o(mem_w16_n), .io_width16_n_o(io_w16_n)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input pcsd_addr_t ad, input pcsd_word_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input pcsd_addr_t ad, input pcsd_word_t e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // Nibble md holds memory-not-io, width, then the two qualifier bits; result is hit, wide.
  function automatic logic [1:0] model_sel(int st, int sp, int up, int md, int ad, int mem,
                                           int rs, int ws, int pin_n);
    int lo, q, hit, wide;
    lo = ad & 'hffff;
    q = md & 3;
    if (md[2]) begin
      lo = lo >> 1;
      st = st >> 1;
      sp = sp >> 1;
    end
    hit = (lo >= st) && (lo <= sp) && ((ad >> 16) == up) && (mem == md[3]) &&
          (q == 3 || (q == 1 && rs != 0) || (q == 2 && ws != 0));
    wide = hit && (md[2] || pin_n == 0);
    return {hit[0], wide[0]};
  endfunction

  initial begin
    #500000;
    errors++;
    report_and_stop();
  end

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    other_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    sys_addr = '0;
    mem_cycle = 1'b0;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    want_mem16 = 1'b0;
    want_io16 = 1'b0;
    errors = 0;
    num_checks = 0;
    void'($urandom(70550));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) rd(offs[i], 16'h0000);
    rd(32'h0b00_032e, 16'h0000);
    for (i = 0; i < 7; i++) wr(offs[i], 16'hffff);
    for (i = 0; i < 7; i++) rd(offs[i], msk[i]);
    @(posedge sys_clk);
    other_reset <= 1'b1;
    @(posedge sys_clk);
    other_reset <= 1'b0;
    for (i = 0; i < 7; i++) rd(offs[i], msk[i]);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) rd(offs[i], 16'h0000);
    // Windows are kept narrow and addresses land near their edges, so boundaries get hit often.
    for (n = 0; n < 300; n++) begin
      @(posedge sys_clk);
      want_mem16 <= 1'($urandom_range(1, 0));
      want_io16 <= 1'($urandom_range(1, 0));
      for (i = 0; i < 7; i++) begin
        // Some passes pin select one to rare modes so the bit-zero and decode cases occur.
        if (i == 6 && n % 4 == 0) cfg[i] = 'hf0 | $urandom_range(15, 0);
        else if (i == 6 && n % 4 == 2) cfg[i] = 'hb0 | $urandom_range(15, 0);
        else if (i == 6) cfg[i] = $urandom_range(255, 0);
        else if (i % 3 == 2) cfg[i] = $urandom_range(3, 0);
        else if (i % 3 == 1) cfg[i] = (cfg[i - 1] + $urandom_range(12, 0) - 2) & 'hffff;
        else cfg[i] = $urandom_range(i == 3 ? 'h7ff0 : 'hfff0, 4);
        wr(offs[i], cfg[i][15:0]);
        exp_q.push_back(cfg[i][15:0] & msk[i]);
      end
      @(posedge sys_clk);
      k = $urandom_range(1, 0);
      a = ((cfg[3 * k + $urandom_range(1, 0)] + $urandom_range(4, 0) - 2) & 'hffff) |
          (($urandom_range(1, 0) ? cfg[3 * k + 2] : $urandom_range(3, 0)) << 16);
      sys_addr <= a[27:0];
      mem_cycle <= 1'($urandom_range(1, 0));
      rd_strobe <= 1'($urandom_range(1, 0));
      wr_strobe <= 1'($urandom_range(1, 0));
      @(posedge sys_clk);
      #1;
      e0 = model_sel(cfg[0], cfg[1], cfg[2], cfg[6] & 15, a, mem_cycle, rd_strobe, wr_strobe,
                     mem_cycle ? mem_w16_n : io_w16_n);
      e1 = model_sel(cfg[3] & 'h7fff, cfg[4], cfg[5], cfg[6] >> 4, a, mem_cycle, rd_strobe,
                     wr_strobe, mem_cycle ? mem_w16_n : io_w16_n);
      chk({14'h0, cs0, c16_0}, {14'h0, e0});
      chk({14'h0, cs1, c16_1}, {14'h0, e1});
      for (i = 0; i < 7; i++) rd(offs[i], exp_q.pop_front());
    end
    report_and_stop();
  end
endmodule // programmable_chip_select_decode_tb_top
